// ===== bench/smu_decoder_model.sv
/*
 * Decoder and register-file side of the multiply unit: a classic
 * Wishbone master that loads operands, starts operations and reads results.
 * Assumes the unit acknowledges every request it is given.
 */
`timescale 1ns/1ps

module smu_decoder_model (
    // clock
    input wire logic clk_sys,
    // wishbone master
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [4:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat,
    input wire logic [31:0] rdat,
    input wire logic ack
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        sel = 4'h0;
        dat = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // single classic cycle, held until ack is sampled
    // ------------------------------------------------------------
    task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d,
                          output logic [31:0] q, input logic [3:0] s = 4'hf);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // released address and data lines show no stale value
        adr <= ~a;
        dat <= ~d;
    endtask
endmodule

// ===== bench/test_smu_multiply_unit.sv
/*
 * Self-checking bench of the multiply unit: runs every operation through
 * the decoder model and compares with a reference worked out here.
 * Assumes a one-cycle exec after each control write.
 */
`timescale 1ns/1ps

module test_smu_multiply_unit;
    logic clk_sys;
    logic nrst;
    logic cyc, stb, we, ack, busy;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat;
    int mismatches = 0;
    int total_checks = 0;

    smu_multiply_unit DUT (.clk_sys(clk_sys), .nrst(nrst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
        .busy(busy));
    smu_decoder_model bus (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(dat), .rdat(rdat), .ack(ack));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // comparison, verdict and reference
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [64:0] model(input logic [31:0] c, a, b, acc, lo, hi);
        logic signed [63:0] p, pw;
        logic [63:0] pr;
        logic signed [31:0] x, w, s;
        logic signed [15:0] hx, hy;
        logic [31:0] y;
        logic [64:0] r;
        r = {1'b0, hi, lo};
        y = c[5] ? {b[15:0], b[31:16]} : b;
        x = $signed(a[15:0]) * $signed(y[15:0]);
        w = $signed(a[31:16]) * $signed(y[31:16]);
        s = x + w;
        p = $signed(a) * $signed(b);
        pr = p + (c[4] ? smu_pkg::ROUND_CONST : 64'h0);
        hx = c[6] ? a[31:16] : a[15:0];
        hy = c[7] ? b[31:16] : b[15:0];
        pw = $signed(a) * hy;
        if (c[8])
            return r;
        case (c[3:0])
            4'h1: r[31:0] = pr[63:32];
            4'h2: r[31:0] = acc + pr[63:32];
            4'h3: r[31:0] = acc - pr[63:32];
            4'h4: r = {(x[31] == w[31]) && (s[31] != x[31]), hi, s};
            4'h5: r[31:0] = x - w;
            4'h6: r[31:0] = hx * hy;
            4'h7: r[31:0] = pw[47:16];
            4'h8: r[63:0] = {32'h0, a} * {32'h0, b};
            4'h9: r[63:0] = {hi, lo} + {32'h0, a} * {32'h0, b};
            4'ha: r[63:0] = p;
            4'hb: r[63:0] = {hi, lo} + p;
            default: ;
        endcase
        return r;
    endfunction

    // loads operands, starts, reads back {flags, high, low}
    task automatic run(input logic [31:0] c, a, b, acc, lo, hi, fl,
                       output logic [95:0] got, output logic [95:0] exp);
        logic [4:0] ofs [7] = '{smu_pkg::OFS_SRC1, smu_pkg::OFS_SRC2, smu_pkg::OFS_ACCUM,
            smu_pkg::OFS_DEST_LOW, smu_pkg::OFS_DEST_HIGH, smu_pkg::OFS_FLAGS,
            smu_pkg::OFS_CTRL};
        logic [31:0] val [7] = '{a, b, acc, lo, hi, fl, c};
        logic [31:0] q, r0, r1, r2;
        logic [64:0] e;
        foreach (ofs[i])
            bus.access(1'b1, ofs[i], val[i], q);
        #1;
        check({31'h0, busy}, 32'h1);
        bus.access(1'b0, smu_pkg::OFS_DEST_LOW, 32'h0, r0);
        bus.access(1'b0, smu_pkg::OFS_DEST_HIGH, 32'h0, r1);
        bus.access(1'b0, smu_pkg::OFS_FLAGS, 32'h0, r2);
        got = {r2, r1, r0};
        e = model(c, a, b, acc, lo, hi);
        exp = {fl | (32'(e[64]) << smu_pkg::FLAG_Q_BIT), e[63:0]};
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        for (int i = 0; i < 8; i++) begin
            bus.access(1'b0, 5'(i * 4), 32'h0, q);
            check(q, smu_pkg::RST_WORD);
        end
    endtask

    // byte lanes merge; unmapped offsets ignore writes and read zero
    task automatic t_lanes();
        logic [31:0] q;
        bus.access(1'b1, smu_pkg::OFS_SRC1, 32'hffff_ffff, q);
        bus.access(1'b1, smu_pkg::OFS_SRC1, 32'h0000_0000, q, 4'h5);
        bus.access(1'b0, smu_pkg::OFS_SRC1, 32'h0, q);
        check(q, 32'hff00_ff00);
        bus.access(1'b1, 5'h1c, 32'h1234_5678, q);
        bus.access(1'b0, 5'h1c, 32'h0, q);
        check(q, smu_pkg::RST_WORD);
    endtask

    task automatic t_msw();
        logic [95:0] g, e;
        logic [31:0] cv [6] = '{32'h01, 32'h11, 32'h02, 32'h12, 32'h03, 32'h13};
        logic [31:0] av [2] = '{32'h0000_c000, 32'hfedc_ba98};
        logic [31:0] bv [2] = '{32'h0001_0000, 32'h1234_5679};
        foreach (cv[i]) foreach (av[j]) begin
            run(cv[i], av[j], bv[j], 32'h0123_4567, 32'h5555_aaaa, 32'h3c3c_c3c3,
                32'h0000_5a5a, g, e);
            check(g[31:0], e[31:0]);
            check(g[95:64], e[95:64]);
        end
    endtask

    task automatic t_dual();
        logic [95:0] g, e;
        logic [31:0] cv [4] = '{32'h04, 32'h24, 32'h05, 32'h25};
        logic [31:0] av [2] = '{32'h0003_fffe, 32'h8000_8000};
        logic [31:0] bv [2] = '{32'h0005_0007, 32'h8000_8000};
        foreach (cv[i]) foreach (av[j]) begin
            run(cv[i], av[j], bv[j], 32'h0, 32'h1111_2222, 32'h0, 32'h0, g, e);
            check(g[31:0], e[31:0]);
            check(g[95:64], e[95:64]);
        end
    endtask

    task automatic t_half();
        logic [95:0] g, e;
        logic [31:0] cv [6] = '{32'h06, 32'h46, 32'h86, 32'hc6, 32'h07, 32'h87};
        foreach (cv[i]) begin
            run(cv[i], 32'hc001_7003, 32'h8002_0fff, 32'h0, 32'h0, 32'h0, 32'h0, g, e);
            check(g[31:0], e[31:0]);
        end
    endtask

    task automatic t_long();
        logic [95:0] g, e;
        logic [31:0] cv [4] = '{32'h08, 32'h09, 32'h0a, 32'h0b};
        foreach (cv[i]) begin
            run(cv[i], 32'hffff_fff0, 32'h8000_0003, 32'h0, 32'hf000_0001, 32'h8000_0000,
                32'h0, g, e);
            check(g[31:0], e[31:0]);
            check(g[63:32], e[63:32]);
        end
    endtask

    task automatic t_cond();
        logic [95:0] g, e;
        logic [31:0] cv [5] = '{32'h104, 32'h109, 32'h113, 32'h00, 32'h0c};
        foreach (cv[i]) begin
            run(cv[i], 32'h8000_8000, 32'h8000_8000, 32'h7, 32'h9876_5432, 32'h0fed_cba9,
                32'h0, g, e);
            check(g[31:0], e[31:0]);
            check(g[63:32], e[63:32]);
            check(g[95:64], e[95:64]);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset();
        t_lanes();
        t_msw();
        t_dual();
        t_half();
        t_long();
        t_cond();
        summarize();
    end

    initial begin
        #1_000_000;
        mismatches++;
        summarize();
    end
endmodule

// ===== design/smu_multiply_unit.sv
/*
 * Multiply datapath with a classic Wishbone register slave.
 * Writing the control register starts one operation on the operand
 * registers; results land in the destination pair one cycle later.
 * Assumes the decoder keeps to the operand restrictions below.
 */
// What this block does
// - msw accumulate and subtract leave all condition flags unchanged.
// - rounding adds 0x80000000 to product before taking upper word.
// - msw multiply is signed 32x32, upper 32 bits to destination.
// - plain msw multiply alters no condition flag.
// - exchange pairs bottom with top; otherwise bottom-bottom, top-top.
// - dual add sums two signed 16x16 products into destination.
// - dual subtract gives bottom product minus top product.
// - dual add sets sticky overflow when the final sum overflows.
// - halfword selector picks bits 15:0 for bottom, 31:16 for top.
// - halfword multiply is signed 16x16 with full 32-bit product.
// - word by half takes upper 32 bits of signed 48-bit product.
// - unsigned long multiply splits product into low and high words.
// - unsigned long accumulate adds product to the destination pair.
// - signed long multiply splits signed product into low and high.
// - signed long accumulate adds signed product to destination pair.
// - msw accumulate adds accumulate value to the upper word.
// - msw subtract takes upper word away from the accumulate value.
`timescale 1ns/1ps

module smu_multiply_unit (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // status
    output logic busy
);

    // ------------------------------------------------------------
    // registers and bus decode
    // ------------------------------------------------------------
    smu_pkg::smu_ctrl_type ctrl;
    smu_pkg::smu_state_type state;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] accum;
    logic [31:0] destLow;
    logic [31:0] destHigh;
    logic [31:0] flags;
    logic [31:0] wrMask;
    logic wrStrobe;
    logic startOp;
    logic doUpdate;
    logic setQ;
    logic [31:0] next_low;
    logic [31:0] next_high;
    logic writesHigh;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wrMask[gi*8 +: 8] = {8{sel_i[gi]}};
        end
    endgenerate

    assign wrStrobe = cyc_i && stb_i && we_i && ack_o;
    assign startOp = wrStrobe && (adr_i == smu_pkg::OFS_CTRL);
    assign doUpdate = (state == smu_pkg::ST_EXEC) && !ctrl.condFail;
    assign busy = (state == smu_pkg::ST_EXEC);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask,
                                          input logic [31:0] data);
        merge = (old & ~mask) | (data & mask);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dat_o <= smu_pkg::RST_WORD;
        end else if (cyc_i && stb_i && !ack_o) begin
            case (adr_i)
                smu_pkg::OFS_CTRL: dat_o <= ctrl;
                smu_pkg::OFS_SRC1: dat_o <= src1;
                smu_pkg::OFS_SRC2: dat_o <= src2;
                smu_pkg::OFS_ACCUM: dat_o <= accum;
                smu_pkg::OFS_DEST_LOW: dat_o <= destLow;
                smu_pkg::OFS_DEST_HIGH: dat_o <= destHigh;
                smu_pkg::OFS_FLAGS: dat_o <= flags;
                default: dat_o <= smu_pkg::RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl <= smu_pkg::smu_ctrl_type'(smu_pkg::RST_WORD);
            src1 <= smu_pkg::RST_WORD;
            src2 <= smu_pkg::RST_WORD;
            accum <= smu_pkg::RST_WORD;
        end else if (wrStrobe) begin
            case (adr_i)
                smu_pkg::OFS_CTRL: ctrl <= smu_pkg::smu_ctrl_type'(merge(ctrl, wrMask, dat_i));
                smu_pkg::OFS_SRC1: src1 <= merge(src1, wrMask, dat_i);
                smu_pkg::OFS_SRC2: src2 <= merge(src2, wrMask, dat_i);
                smu_pkg::OFS_ACCUM: accum <= merge(accum, wrMask, dat_i);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= smu_pkg::ST_IDLE;
        end else begin
            case (state)
                smu_pkg::ST_IDLE: if (startOp) state <= smu_pkg::ST_EXEC;
                smu_pkg::ST_EXEC: state <= smu_pkg::ST_IDLE;
                default: state <= smu_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic signed [63:0] wideA;
    logic signed [63:0] wideB;
    logic signed [63:0] prodSigned;
    logic [63:0] prodUnsigned;
    logic [63:0] prodRounded;
    logic [31:0] upperWord;
    logic [31:0] swapped;
    logic signed [31:0] hA0;
    logic signed [31:0] hA1;
    logic signed [31:0] hB0;
    logic signed [31:0] hB1;
    logic signed [31:0] dualP0;
    logic signed [31:0] dualP1;
    logic [32:0] dualSum;
    logic [31:0] dualDiff;
    logic [15:0] selX;
    logic [15:0] selY;
    logic signed [31:0] halfProd;
    logic signed [47:0] wxhA;
    logic signed [47:0] wxhB;
    logic signed [47:0] wxhProd;
    logic [63:0] pair;

    assign wideA = {{32{src1[31]}}, src1};
    assign wideB = {{32{src2[31]}}, src2};
    assign prodSigned = wideA * wideB;
    assign prodUnsigned = {32'h0000_0000, src1} * {32'h0000_0000, src2};
    assign prodRounded = ctrl.round ? prodSigned + smu_pkg::ROUND_CONST : prodSigned;
    assign upperWord = prodRounded[63:32];

    assign swapped = ctrl.exchange ? {src2[15:0], src2[31:16]} : src2;
    assign hA0 = {{16{src1[15]}}, src1[15:0]};
    assign hA1 = {{16{src1[31]}}, src1[31:16]};
    assign hB0 = {{16{swapped[15]}}, swapped[15:0]};
    assign hB1 = {{16{swapped[31]}}, swapped[31:16]};
    assign dualP0 = hA0 * hB0;
    assign dualP1 = hA1 * hB1;
    assign dualSum = {dualP0[31], dualP0} + {dualP1[31], dualP1};
    assign dualDiff = dualP0 - dualP1;

    assign selX = ctrl.xTop ? src1[31:16] : src1[15:0];
    assign selY = ctrl.yTop ? src2[31:16] : src2[15:0];
    assign halfProd = $signed({{16{selX[15]}}, selX}) * $signed({{16{selY[15]}}, selY});
    assign wxhA = {{16{src1[31]}}, src1};
    assign wxhB = {{32{selY[15]}}, selY};
    assign wxhProd = wxhA * wxhB;
    assign pair = {destHigh, destLow};

    always_comb begin
        next_low = destLow;
        next_high = destHigh;
        writesHigh = 1'b0;
        setQ = 1'b0;
        case (ctrl.op)
            smu_pkg::OP_MSW_MULTIPLY: next_low = upperWord;
            smu_pkg::OP_MSW_MULT_ACCUMULATE: next_low = accum + upperWord;
            smu_pkg::OP_MSW_MULT_SUBTRACT: next_low = accum - upperWord;
            smu_pkg::OP_DUAL_MULT_ADD: begin
                next_low = dualSum[31:0];
                setQ = dualSum[32] != dualSum[31];
            end
            smu_pkg::OP_DUAL_MULT_SUB: next_low = dualDiff;
            smu_pkg::OP_HALFWORD_MULTIPLY: next_low = halfProd;
            smu_pkg::OP_WORD_BY_HALF_MULTIPLY: next_low = wxhProd[47:16];
            smu_pkg::OP_UNSIGNED_LONG_MULTIPLY: begin
                {next_high, next_low} = prodUnsigned;
                writesHigh = 1'b1;
            end
            smu_pkg::OP_UNSIGNED_LONG_MULT_ACC: begin
                {next_high, next_low} = pair + prodUnsigned;
                writesHigh = 1'b1;
            end
            smu_pkg::OP_SIGNED_LONG_MULTIPLY: begin
                {next_high, next_low} = prodSigned;
                writesHigh = 1'b1;
            end
            smu_pkg::OP_SIGNED_LONG_MULT_ACC: begin
                {next_high, next_low} = pair + prodSigned;
                writesHigh = 1'b1;
            end
            default: ;
        endcase
    end

    // destination pair: software writes, results override in the exec cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            destLow <= smu_pkg::RST_WORD;
            destHigh <= smu_pkg::RST_WORD;
        end else if (doUpdate) begin
            destLow <= next_low;
            if (writesHigh) destHigh <= next_high;
        end else if (wrStrobe && adr_i == smu_pkg::OFS_DEST_LOW) begin
            destLow <= merge(destLow, wrMask, dat_i);
        end else if (wrStrobe && adr_i == smu_pkg::OFS_DEST_HIGH) begin
            destHigh <= merge(destHigh, wrMask, dat_i);
        end
    end

    // flags: operations only ever set sticky overflow; set beats a software clear
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flags <= smu_pkg::RST_WORD;
        end else begin
            if (wrStrobe && adr_i == smu_pkg::OFS_FLAGS) flags <= merge(flags, wrMask, dat_i);
            if (doUpdate && setQ) flags[smu_pkg::FLAG_Q_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence execOf(smu_pkg::smu_op_type o);
        state == smu_pkg::ST_EXEC && !ctrl.condFail && ctrl.op == o;
    endsequence

    sequence execMsw;
        state == smu_pkg::ST_EXEC && !ctrl.condFail && (ctrl.op == smu_pkg::OP_MSW_MULTIPLY ||
            ctrl.op == smu_pkg::OP_MSW_MULT_ACCUMULATE || ctrl.op == smu_pkg::OP_MSW_MULT_SUBTRACT);
    endsequence

    chk_msw_round: assert property (execOf(smu_pkg::OP_MSW_MULTIPLY) |=> destLow ==
        32'((64'($signed(src1)) * 64'($signed(src2))
          + ($past(ctrl.round) ? 64'h8000_0000 : 64'h0)) >> 32))
        else $error("msw multiply result wrong");
    chk_msw_flags: assert property (execMsw |=> flags == $past(flags))
        else $error("msw operation changed flags");
    chk_msw_sub: assert property (execOf(smu_pkg::OP_MSW_MULT_SUBTRACT) |=>
        destLow + $past(upperWord) == accum)
        else $error("msw subtract result wrong");
    chk_dual_sub: assert property (execOf(smu_pkg::OP_DUAL_MULT_SUB) |=> destLow ==
        32'($signed(src1[15:0]) * $signed(ctrl.exchange ? src2[31:16] : src2[15:0])
          - $signed(src1[31:16]) * $signed(ctrl.exchange ? src2[15:0] : src2[31:16])))
        else $error("dual subtract result wrong");
    chk_dual_ovf: assert property (execOf(smu_pkg::OP_DUAL_MULT_ADD) ##0 dualSum[32] != dualSum[31]
        |=> flags[smu_pkg::FLAG_Q_BIT] ##1 flags[smu_pkg::FLAG_Q_BIT] || wrStrobe)
        else $error("sticky overflow not set");
    chk_half_mult: assert property (execOf(smu_pkg::OP_HALFWORD_MULTIPLY) |=> destLow ==
        32'($signed(ctrl.xTop ? src1[31:16] : src1[15:0]) *
            $signed(ctrl.yTop ? src2[31:16] : src2[15:0])))
        else $error("halfword multiply result wrong");
    chk_ulong_acc: assert property (execOf(smu_pkg::OP_UNSIGNED_LONG_MULT_ACC) |=>
        {destHigh, destLow} == $past(pair) + 64'(src1) * 64'(src2))
        else $error("unsigned long accumulate wrong");
    chk_cond_fail: assert property (state == smu_pkg::ST_EXEC && ctrl.condFail |=>
        $stable(destLow) && $stable(destHigh) && $stable(flags))
        else $error("failed condition changed state");
    chk_one_exec: assert property (state == smu_pkg::ST_EXEC |=> state == smu_pkg::ST_IDLE)
        else $error("exec lasted more than one cycle");
    chk_msw_acc: assert property (execOf(smu_pkg::OP_MSW_MULT_ACCUMULATE) |=> destLow ==
        accum + 32'((64'($signed(src1)) * 64'($signed(src2))
          + (ctrl.round ? 64'h8000_0000 : 64'h0)) >> 32))
        else $error("msw accumulate result wrong");
    chk_dual_add: assert property (execOf(smu_pkg::OP_DUAL_MULT_ADD) |=> destLow ==
        32'($signed(src1[15:0]) * $signed(ctrl.exchange ? src2[31:16] : src2[15:0])
          + $signed(src1[31:16]) * $signed(ctrl.exchange ? src2[15:0] : src2[31:16])))
        else $error("dual add result wrong");
    chk_word_half: assert property (execOf(smu_pkg::OP_WORD_BY_HALF_MULTIPLY) |=>
        destLow == 32'((48'($signed(src1))
          * 48'($signed(ctrl.yTop ? src2[31:16] : src2[15:0]))) >> 16))
        else $error("word by half result wrong");
    chk_slong_acc: assert property (execOf(smu_pkg::OP_SIGNED_LONG_MULT_ACC) |=>
        {destHigh, destLow} == $past(pair) + 64'($signed(src1)) * 64'($signed(src2)))
        else $error("signed long accumulate wrong");

endmodule

// ===== shared/smu_pkg.sv
/*
 * Constants and types of the signed/unsigned multiply unit: register map,
 * control field layout, operation codes and the sequencer state type.
 * Assumes a 32-bit classic Wishbone master reaching the unit's registers.
 */
package smu_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_SRC1 = 5'h04;
    localparam logic [4:0] OFS_SRC2 = 5'h08;
    localparam logic [4:0] OFS_ACCUM = 5'h0c;
    localparam logic [4:0] OFS_DEST_LOW = 5'h10;
    localparam logic [4:0] OFS_DEST_HIGH = 5'h14;
    localparam logic [4:0] OFS_FLAGS = 5'h18;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int FLAG_Q_BIT = 27;
    localparam logic [63:0] ROUND_CONST = 64'h0000_0000_8000_0000;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_MSW_MULTIPLY = 4'h1,
        OP_MSW_MULT_ACCUMULATE = 4'h2,
        OP_MSW_MULT_SUBTRACT = 4'h3,
        OP_DUAL_MULT_ADD = 4'h4,
        OP_DUAL_MULT_SUB = 4'h5,
        OP_HALFWORD_MULTIPLY = 4'h6,
        OP_WORD_BY_HALF_MULTIPLY = 4'h7,
        OP_UNSIGNED_LONG_MULTIPLY = 4'h8,
        OP_UNSIGNED_LONG_MULT_ACC = 4'h9,
        OP_SIGNED_LONG_MULTIPLY = 4'ha,
        OP_SIGNED_LONG_MULT_ACC = 4'hb
    } smu_op_type;

    // control word, bit 0 upward: op, round, exchange, xTop, yTop, condFail
    typedef struct packed {
        logic [22:0] spare;
        logic condFail;
        logic yTop;
        logic xTop;
        logic exchange;
        logic round;
        smu_op_type op;
    } smu_ctrl_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } smu_state_type;

endpackage
